// ### shared/ifm_pkg.sv
/*
  Constants, modes and carrier types of the twelve-port ingress FIFO mode and partition block.
  Assumes one core clock; shared by the control top and its region helper.
*/
package ifm_pkg;
  localparam int NPORT       = 12;
  localparam int PTR_W       = 14;
  localparam int ADDR_W      = 7;
  localparam int BLOCK_BYTES = 2048;
  localparam int PLANE_BYTES = 32;
  localparam int RESV_BYTES  = 128;
  localparam int UNIT_SHIFT  = $clog2(BLOCK_BYTES / PLANE_BYTES);
  localparam logic [PTR_W-1:0] RESV_PLANES = PTR_W'(RESV_BYTES / PLANE_BYTES);
  localparam logic [2:0] SMALL_PLANES = 3'h4;
  localparam logic [2:0] FLEN_MAX     = 3'h7;

  // Register groups: address bits 6:4, buffer index in bits 3:0
  localparam logic [2:0] GRP_DIAG   = 3'h0;
  localparam logic [2:0] GRP_BOUNDS = 3'h1;
  localparam logic [2:0] GRP_WPTR   = 3'h2;
  localparam logic [2:0] GRP_RPTR   = 3'h3;
  localparam logic [2:0] GRP_THRESH = 3'h5;
  localparam logic [2:0] GRP_DROP   = 3'h6;
  localparam logic [2:0] GRP_DEBUG  = 3'h7;
  localparam logic [ADDR_W-1:0] ADDR_GCTL = 7'h7F;

  localparam int BIT_FORCE_TX = 31;
  localparam int BIT_FORCE_RX = 30;
  localparam int BIT_FAIR     = 25;
  localparam int EV_LSB       = 16;
  localparam int NEV          = 9;
  localparam int FLAG_LSB     = 8;
  localparam int NFLAG        = 8;
  localparam int BIT_CLASS    = 7;
  localparam int BIT_SKIP     = 6;
  localparam int BIT_FAIL     = 5;
  localparam int BIT_KEEP     = 4;
  localparam int MODE_W       = 4;
  localparam int TOP_LSB      = 16;
  localparam int BOT_LSB      = 0;
  localparam int THR_LSB      = 16;
  localparam int GCTL_CLR     = 0;
  localparam int GCTL_LEN     = 1;

  localparam int FL_SEQ_PLAIN = 0;
  localparam int FL_SEQ_LEN   = 1;
  localparam int FL_AGED      = 2;
  localparam int FL_FLOWCTL   = 3;
  localparam int FL_EARLY_ABT = 4;
  localparam int FL_EMPTY     = 5;
  localparam int FL_FULL      = 6;
  localparam int FL_EARLY     = 7;

  localparam int EV_FRAME   = 0;
  localparam int EV_START   = 1;
  localparam int EV_MID     = 2;
  localparam int EV_END     = 3;
  localparam int EV_SMALL   = 4;
  localparam int EV_LARGE   = 5;
  localparam int EV_SHORT   = 6;
  localparam int EV_DISCARD = 7;
  localparam int EV_READ    = 8;

  localparam logic [31:0]      DIAG_RST = 32'h2000_0002;
  localparam logic [31:0]      CFG_MASK = 32'hFFFF_00FF;
  localparam logic [NFLAG-1:0] FLAG_RST = 8'h20;

  typedef enum logic [MODE_W-1:0] {
    MODE_NORMAL  = 4'h0,
    MODE_RX_STOP = 4'h1,
    MODE_CLEAR   = 4'h2,
    MODE_TX_STOP = 4'h3,
    MODE_REPLAY  = 4'h4,
    MODE_RTT     = 4'hC
  } ifm_mode_e;

  typedef enum logic [1:0] {
    KIND_MID    = 2'h0,
    KIND_START  = 2'h1,
    KIND_END    = 2'h2,
    KIND_SINGLE = 2'h3
  } ifm_kind_e;

  typedef struct packed {
    logic      valid;
    logic [3:0] port;
    ifm_kind_e kind;
    logic      bad;
    logic      abort;
    logic      hiprio;
  } ifm_rx_s;

  typedef struct packed {
    logic       valid;
    logic [3:0] port;
  } ifm_req_s;

  typedef struct packed {
    logic             valid;
    logic [3:0]       port;
    logic [PTR_W-1:0] addr;
  } ifm_mem_s;

  typedef struct packed {
    logic [7:0] top;
    logic [7:0] bottom;
  } ifm_bounds_s;

  function automatic logic rx_accepts(input logic [MODE_W-1:0] m);
    return m == MODE_NORMAL || m == MODE_TX_STOP;
  endfunction
endpackage

// ### hw/ifm_region.sv
/*
  Region arithmetic of one ingress buffer: base, wrapping successors, fill, empty, full.
  Assumes pointers in 32-byte planes and bounds in 2048-byte blocks; purely combinational.
*/
`timescale 1ns/100ps
module ifm_region
(
  input  ifm_pkg::ifm_bounds_s      bounds,
  input  logic [ifm_pkg::PTR_W-1:0] wr_ptr,
  input  logic [ifm_pkg::PTR_W-1:0] rd_ptr,
  output logic [ifm_pkg::PTR_W-1:0] base,
  output logic [ifm_pkg::PTR_W-1:0] wr_next,
  output logic [ifm_pkg::PTR_W-1:0] rd_next,
  output logic [ifm_pkg::PTR_W-1:0] fill,
  output logic                      empty,
  output logic                      full
);
  import ifm_pkg::*;

  logic [PTR_W-1:0] lim;
  logic [PTR_W-1:0] size;
  logic [PTR_W-1:0] wr_inc;
  logic [PTR_W-1:0] rd_inc;
  logic [PTR_W-1:0] diff;

  // A top of zero wraps to the end of memory, which the 14-bit sum reaches naturally
  assign base    = PTR_W'(bounds.bottom) << UNIT_SHIFT;
  assign lim     = PTR_W'(bounds.top) << UNIT_SHIFT;
  assign size    = PTR_W'(8'(bounds.top - bounds.bottom)) << UNIT_SHIFT;
  assign wr_inc  = wr_ptr + 14'h1;
  assign rd_inc  = rd_ptr + 14'h1;
  assign wr_next = (wr_inc == lim) ? base : wr_inc;
  assign rd_next = (rd_inc == lim) ? base : rd_inc;
  assign diff    = wr_ptr - rd_ptr;
  assign fill    = (wr_ptr >= rd_ptr) ? diff : diff + size;
  assign empty   = wr_ptr == rd_ptr;
  // Four planes stay unused so a full buffer never looks empty
  assign full    = fill >= size - RESV_PLANES;
endmodule

// ### hw/ifm_ctrl.sv
/*
  Mode, diagnostics, dropping and partition control for twelve ingress FIFO buffers.
  Assumes one core clock; plane, request and register strobes come from same-clock logic.
*/
`timescale 1ns/100ps
module ifm_ctrl
(
  input  logic                       CLOCK,
  input  logic                       NRST,
  input  logic                       FIFO_RST,
  input  logic [ifm_pkg::ADDR_W-1:0] REG_ADDR,
  input  logic [31:0]                REG_WDATA,
  input  logic                       REG_WR,
  input  logic                       REG_RD,
  output logic [31:0]                REG_RDATA,
  input  ifm_pkg::ifm_rx_s           RX_PLANE,
  input  logic [ifm_pkg::NPORT-1:0]  RX_FLOWCTL,
  input  logic [ifm_pkg::NPORT-1:0]  RX_AGED,
  output ifm_pkg::ifm_mem_s          WR_CMD,
  input  ifm_pkg::ifm_req_s          TX_REQ,
  output logic                       TX_GRANT,
  output ifm_pkg::ifm_mem_s          RD_CMD
);
  import ifm_pkg::*;

  logic [2:0]       reg_grp;
  logic [3:0]       reg_idx;
  logic             gctl_hit;
  logic             gclr_ff;
  logic             lenstore_ff;
  logic [NPORT-1:0] store_v;
  logic [NPORT-1:0] grant_v;
  logic [31:0]      cfg_ff      [NPORT];
  logic [NFLAG-1:0] flag_ff     [NPORT];
  ifm_bounds_s      bounds_ff   [NPORT];
  logic [PTR_W-1:0] thr_ff      [NPORT];
  logic [PTR_W-1:0] wptr_ff     [NPORT];
  logic [PTR_W-1:0] rptr_ff     [NPORT];
  logic [31:0]      drop_cnt_ff [NPORT];
  logic [31:0]      dbg_cnt_ff  [NPORT];
  logic [3:0]       rx_pidx;
  logic [3:0]       tx_pidx;
  logic [31:0]      nxt_rdata;

  function automatic logic reg_sel(input logic [ADDR_W-1:0] a, input logic [2:0] g, input logic [3:0] n);
    return a[6:4] == g && a[3:0] == n;
  endfunction

  assign reg_grp  = REG_ADDR[6:4];
  assign reg_idx  = REG_ADDR[3:0];
  assign gctl_hit = REG_ADDR == ADDR_GCTL;
  assign rx_pidx  = (RX_PLANE.port < 4'(NPORT)) ? RX_PLANE.port : 4'h0;
  assign tx_pidx  = (TX_REQ.port < 4'(NPORT)) ? TX_REQ.port : 4'h0;
  assign TX_GRANT = |grant_v;

  always_ff @(posedge CLOCK or negedge NRST)
  begin
    if (!NRST)
    begin
      gclr_ff     <= 1'b0;
      lenstore_ff <= 1'b0;
    end
    else if (REG_WR && gctl_hit)
    begin
      gclr_ff     <= REG_WDATA[GCTL_CLR];
      lenstore_ff <= REG_WDATA[GCTL_LEN];
    end
  end

  for (genvar i = 0; i < NPORT; i++)
  begin : g_port
    ifm_mode_e        mode;
    logic [PTR_W-1:0] base;
    logic [PTR_W-1:0] wnext;
    logic [PTR_W-1:0] rnext;
    logic [PTR_W-1:0] fill;
    logic [PTR_W-1:0] back_ptr;
    logic             empty;
    logic             full;
    logic             wr_diag;
    logic             clearing;
    logic             hit_rx;
    logic             hit_tx;
    logic             rx_ok;
    logic             is_start;
    logic             is_end;
    logic             dropping;
    logic             ovf;
    logic             new_drop;
    logic             store;
    logic             bad_end;
    logic             discard_bad;
    logic             rollback;
    logic             seq_err;
    logic             avail;
    logic             grant;
    logic             ev;
    logic             rxstop_entry;
    logic             cnt_drop;
    logic [NEV-1:0]   ev_v;
    logic [NFLAG-1:0] set_v;
    logic [MODE_W-1:0] nxt_mode;
    logic [31:0]      cfg_src;
    logic             in_frame_ff;
    logic             drop_ff;
    logic             was_full_ff;
    logic             rd_in_wframe_ff;
    logic [PTR_W-1:0] fstart_ff;
    logic [PTR_W-1:0] rtt_start_ff;
    logic [2:0]       flen_ff;

    ifm_region u_region
    (
      .bounds  (bounds_ff[i]),
      .wr_ptr  (wptr_ff[i]),
      .rd_ptr  (rptr_ff[i]),
      .base    (base),
      .wr_next (wnext),
      .rd_next (rnext),
      .fill    (fill),
      .empty   (empty),
      .full    (full)
    );

    assign mode     = ifm_mode_e'(cfg_ff[i][MODE_W-1:0]);
    assign wr_diag  = REG_WR && reg_sel(REG_ADDR, GRP_DIAG, 4'(i));
    assign clearing = gclr_ff || mode == MODE_CLEAR;
    assign hit_rx   = RX_PLANE.valid && RX_PLANE.port == 4'(i);
    assign hit_tx   = TX_REQ.valid && TX_REQ.port == 4'(i);
    assign rx_ok    = rx_accepts(mode) && !gclr_ff;
    assign is_start = RX_PLANE.kind == KIND_START || RX_PLANE.kind == KIND_SINGLE;
    assign is_end   = RX_PLANE.kind == KIND_END || RX_PLANE.kind == KIND_SINGLE;
    assign dropping = drop_ff && !is_start;

    // Without fairness every plane is judged, so long frames are cut more often
    assign ovf = full || (cfg_ff[i][BIT_CLASS] && !RX_PLANE.hiprio && fill > thr_ff[i]
                          && (is_start || !cfg_ff[i][BIT_FAIR]));
    assign new_drop    = hit_rx && rx_ok && !dropping && ovf;
    assign store       = hit_rx && rx_ok && !dropping && !ovf;
    assign bad_end     = store && is_end && (RX_PLANE.bad || RX_PLANE.abort);
    assign discard_bad = bad_end && !(cfg_ff[i][BIT_KEEP] && rd_in_wframe_ff);
    assign rollback    = discard_bad || (new_drop && !is_start && in_frame_ff);
    // Planes already sent cannot be recalled, so only the unread tail is given back
    assign back_ptr    = rd_in_wframe_ff ? rptr_ff[i] : fstart_ff;
    assign seq_err     = hit_rx && rx_ok && (RX_PLANE.abort || is_start == in_frame_ff
                         || (was_full_ff && !full && !is_start));

    always_comb
    begin
      avail = 1'b0;
      unique case (mode)
        MODE_NORMAL, MODE_RX_STOP: avail = !empty;
        MODE_REPLAY:               avail = 1'b1;
        MODE_RTT:                  avail = rtt_start_ff != wptr_ff[i];
        default:                   avail = 1'b0;
      endcase
    end

    assign grant       = hit_tx && avail && !gclr_ff;
    assign store_v[i]  = store && !discard_bad;
    assign grant_v[i]  = grant;

    assign ev_v[EV_FRAME]   = store && RX_PLANE.kind == KIND_END && !bad_end;
    assign ev_v[EV_START]   = hit_rx && RX_PLANE.kind == KIND_START;
    assign ev_v[EV_MID]     = hit_rx && RX_PLANE.kind == KIND_MID;
    assign ev_v[EV_END]     = hit_rx && RX_PLANE.kind == KIND_END;
    assign ev_v[EV_SMALL]   = store && is_end && !bad_end && (is_start || flen_ff < SMALL_PLANES);
    assign ev_v[EV_LARGE]   = store && is_end && !bad_end && !is_start && flen_ff >= SMALL_PLANES;
    assign ev_v[EV_SHORT]   = store && RX_PLANE.kind == KIND_SINGLE;
    assign ev_v[EV_DISCARD] = hit_rx && !store_v[i];
    assign ev_v[EV_READ]    = grant;
    assign ev = |(ev_v & cfg_ff[i][EV_LSB +: NEV]);

    always_comb
    begin
      nxt_mode = cfg_ff[i][MODE_W-1:0];
      if (wr_diag)
        nxt_mode = REG_WDATA[MODE_W-1:0];
      if (ev && cfg_ff[i][BIT_FORCE_RX])
        nxt_mode = MODE_RX_STOP;
      if (ev && cfg_ff[i][BIT_FORCE_TX])
        nxt_mode = MODE_TX_STOP;
    end

    assign rxstop_entry = nxt_mode == MODE_RX_STOP && mode != MODE_RX_STOP;
    assign cnt_drop = (new_drop && !(cfg_ff[i][BIT_SKIP] && rd_in_wframe_ff))
                      || (discard_bad && cfg_ff[i][BIT_FAIL])
                      || (hit_rx && mode == MODE_CLEAR && is_start)
                      || rxstop_entry;
    assign cfg_src  = wr_diag ? (REG_WDATA & CFG_MASK) : cfg_ff[i];

    always_ff @(posedge CLOCK or negedge NRST)
    begin
      if (!NRST)
        cfg_ff[i] <= DIAG_RST;
      else
        cfg_ff[i] <= {cfg_src[31:MODE_W], nxt_mode};
    end

    always_comb
    begin
      set_v               = '0;
      set_v[FL_SEQ_PLAIN] = seq_err && !lenstore_ff;
      set_v[FL_SEQ_LEN]   = seq_err && lenstore_ff;
      set_v[FL_AGED]      = RX_AGED[i];
      set_v[FL_FLOWCTL]   = RX_FLOWCTL[i];
      set_v[FL_EARLY_ABT] = hit_rx && RX_PLANE.abort && rd_in_wframe_ff;
      set_v[FL_EMPTY]     = empty;
      set_v[FL_FULL]      = full || (mode == MODE_REPLAY && grant && rptr_ff[i] == base);
      set_v[FL_EARLY]     = grant && (rd_in_wframe_ff
                            || (in_frame_ff && !drop_ff && rptr_ff[i] == fstart_ff));
    end

    // A flag raised in the same cycle as its clear stays set
    always_ff @(posedge CLOCK or negedge NRST)
    begin
      if (!NRST)
        flag_ff[i] <= FLAG_RST;
      else if (FIFO_RST)
        flag_ff[i] <= FLAG_RST;
      else if (wr_diag)
        flag_ff[i] <= (flag_ff[i] & ~REG_WDATA[FLAG_LSB +: NFLAG]) | set_v;
      else
        flag_ff[i] <= flag_ff[i] | set_v;
    end

    always_ff @(posedge CLOCK or negedge NRST)
    begin
      if (!NRST)
        wptr_ff[i] <= '0;
      else if (clearing)
        wptr_ff[i] <= base;
      else if (rollback)
        wptr_ff[i] <= back_ptr;
      else if (store)
        wptr_ff[i] <= wnext;
    end

    always_ff @(posedge CLOCK or negedge NRST)
    begin
      if (!NRST)
        rptr_ff[i] <= '0;
      else if (clearing)
        rptr_ff[i] <= base;
      else if (grant && mode == MODE_RTT && rnext == wptr_ff[i])
        rptr_ff[i] <= rtt_start_ff;
      else if (grant)
        rptr_ff[i] <= rnext;
    end

    always_ff @(posedge CLOCK or negedge NRST)
    begin
      if (!NRST)
        rtt_start_ff <= '0;
      else if (nxt_mode == MODE_RTT && mode != MODE_RTT)
        rtt_start_ff <= rptr_ff[i];
    end

    always_ff @(posedge CLOCK or negedge NRST)
    begin
      if (!NRST)
      begin
        in_frame_ff <= 1'b0;
        drop_ff     <= 1'b0;
        was_full_ff <= 1'b0;
        fstart_ff   <= '0;
        flen_ff     <= '0;
      end
      else if (clearing)
      begin
        in_frame_ff <= 1'b0;
        drop_ff     <= 1'b0;
        was_full_ff <= 1'b0;
      end
      else if (hit_rx && rx_ok)
      begin
        in_frame_ff <= !is_end && (is_start || in_frame_ff);
        drop_ff     <= !is_end && (dropping || new_drop);
        was_full_ff <= full;
        if (store && is_start)
          fstart_ff <= wptr_ff[i];
        if (is_start)
          flen_ff <= 3'h1;
        else if (flen_ff != FLEN_MAX)
          flen_ff <= flen_ff + 3'h1;
      end
    end

    always_ff @(posedge CLOCK or negedge NRST)
    begin
      if (!NRST)
        rd_in_wframe_ff <= 1'b0;
      else if (clearing || (hit_rx && rx_ok && (is_start || is_end)))
        rd_in_wframe_ff <= 1'b0;
      else if (grant && in_frame_ff && !drop_ff && rptr_ff[i] == fstart_ff)
        rd_in_wframe_ff <= 1'b1;
    end

    always_ff @(posedge CLOCK or negedge NRST)
    begin
      if (!NRST)
        drop_cnt_ff[i] <= '0;
      else if (REG_WR && reg_sel(REG_ADDR, GRP_DROP, 4'(i)))
        drop_cnt_ff[i] <= '0;
      else if (cnt_drop)
        drop_cnt_ff[i] <= drop_cnt_ff[i] + 32'h1;
    end

    // Wraps without saturating; simultaneous events add one
    always_ff @(posedge CLOCK or negedge NRST)
    begin
      if (!NRST)
        dbg_cnt_ff[i] <= '0;
      else if (REG_WR && reg_sel(REG_ADDR, GRP_DEBUG, 4'(i)))
        dbg_cnt_ff[i] <= REG_WDATA;
      else if (ev)
        dbg_cnt_ff[i] <= dbg_cnt_ff[i] + 32'h1;
    end

    always_ff @(posedge CLOCK or negedge NRST)
    begin
      if (!NRST)
      begin
        bounds_ff[i] <= '0;
        thr_ff[i]    <= '0;
      end
      else
      begin
        if (REG_WR && reg_sel(REG_ADDR, GRP_BOUNDS, 4'(i)) && clearing)
        begin
          bounds_ff[i].top    <= REG_WDATA[TOP_LSB +: 8];
          bounds_ff[i].bottom <= REG_WDATA[BOT_LSB +: 8];
        end
        if (REG_WR && reg_sel(REG_ADDR, GRP_THRESH, 4'(i)))
          thr_ff[i] <= REG_WDATA[THR_LSB +: PTR_W];
      end
    end
  end

  always_ff @(posedge CLOCK or negedge NRST)
  begin
    if (!NRST)
    begin
      WR_CMD <= '0;
      RD_CMD <= '0;
    end
    else
    begin
      WR_CMD.valid <= |store_v;
      WR_CMD.port  <= RX_PLANE.port;
      WR_CMD.addr  <= wptr_ff[rx_pidx];
      RD_CMD.valid <= |grant_v;
      RD_CMD.port  <= TX_REQ.port;
      RD_CMD.addr  <= rptr_ff[tx_pidx];
    end
  end

  always_comb
  begin
    nxt_rdata = '0;
    if (gctl_hit)
    begin
      nxt_rdata[GCTL_CLR] = gclr_ff;
      nxt_rdata[GCTL_LEN] = lenstore_ff;
    end
    else if (reg_idx < 4'(NPORT))
    begin
      unique case (reg_grp)
        GRP_DIAG:
        begin
          nxt_rdata = cfg_ff[reg_idx];
          nxt_rdata[FLAG_LSB +: NFLAG] = flag_ff[reg_idx];
          if (cfg_ff[reg_idx][BIT_CLASS])
            nxt_rdata[FLAG_LSB + FL_FULL] = 1'b0;
        end
        GRP_BOUNDS:
        begin
          nxt_rdata[TOP_LSB +: 8] = bounds_ff[reg_idx].top;
          nxt_rdata[BOT_LSB +: 8] = bounds_ff[reg_idx].bottom;
        end
        GRP_WPTR:   nxt_rdata[PTR_W-1:0] = wptr_ff[reg_idx];
        GRP_RPTR:   nxt_rdata[PTR_W-1:0] = rptr_ff[reg_idx];
        GRP_THRESH: nxt_rdata[THR_LSB +: PTR_W] = thr_ff[reg_idx];
        GRP_DROP:   nxt_rdata = drop_cnt_ff[reg_idx];
        GRP_DEBUG:  nxt_rdata = dbg_cnt_ff[reg_idx];
        default:    nxt_rdata = '0;
      endcase
    end
  end

  always_ff @(posedge CLOCK or negedge NRST)
  begin
    if (!NRST)
      REG_RDATA <= '0;
    else
      REG_RDATA <= REG_RD ? nxt_rdata : 32'h0;
  end
endmodule

// ### bench/ifm_ctrl_sva.sv
/*
  Port-level checker for ifm_ctrl, bound to every instance.
  Assumes one core clock and the active-low asynchronous reset NRST.
*/
`timescale 1ns/100ps
module ifm_ctrl_sva
(
  input wire logic                       CLOCK,
  input wire logic                       NRST,
  input wire logic                       FIFO_RST,
  input wire logic [ifm_pkg::ADDR_W-1:0] REG_ADDR,
  input wire logic [31:0]                REG_WDATA,
  input wire logic                       REG_WR,
  input wire logic                       REG_RD,
  input wire logic [31:0]                REG_RDATA,
  input ifm_pkg::ifm_rx_s                RX_PLANE,
  input wire logic [ifm_pkg::NPORT-1:0]  RX_FLOWCTL,
  input wire logic [ifm_pkg::NPORT-1:0]  RX_AGED,
  input ifm_pkg::ifm_mem_s               WR_CMD,
  input ifm_pkg::ifm_req_s               TX_REQ,
  input wire logic                       TX_GRANT,
  input ifm_pkg::ifm_mem_s               RD_CMD
);
  import ifm_pkg::*;
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!NRST);

  a_rdata_lone: assert property (REG_RDATA != 32'h0 |-> $past(REG_RD))
    else $error("read data without read strobe");
  a_unmapped_zero: assert property (REG_RD && (REG_ADDR[6:4] == 3'h4 ||
    (REG_ADDR[3:0] > 4'hB && REG_ADDR != ADDR_GCTL)) |=> REG_RDATA == 32'h0)
    else $error("unmapped read not zero");
  a_grant_needs_req: assert property (TX_GRANT |-> TX_REQ.valid)
    else $error("grant without request");
  a_grant_to_read: assert property (TX_REQ.valid && TX_GRANT |=> RD_CMD.valid &&
    RD_CMD.port == $past(TX_REQ.port))
    else $error("grant not followed by memory read");
  a_read_cause: assert property (RD_CMD.valid |-> $past(TX_REQ.valid && TX_GRANT))
    else $error("memory read without grant");
  a_write_cause: assert property (WR_CMD.valid |-> $past(RX_PLANE.valid) &&
    WR_CMD.port == $past(RX_PLANE.port))
    else $error("memory write without plane");
  a_empty_after_rst: assert property (FIFO_RST && $past(FIFO_RST) && REG_RD &&
    REG_ADDR[6:4] == GRP_DIAG && REG_ADDR[3:0] < 4'hC |=> REG_RDATA[13])
    else $error("empty flag not set by fifo reset");
  a_flowctl_sticky: assert property ((RX_FLOWCTL[0] && !FIFO_RST) ##1 (!FIFO_RST && !REG_WR) ##1
    (REG_RD && REG_ADDR == 7'h00 && !FIFO_RST) |=> REG_RDATA[11])
    else $error("flow control flag missing");
  a_aged_sticky: assert property ((RX_AGED[0] && !FIFO_RST) ##1 (!FIFO_RST && !REG_WR) ##1
    (REG_RD && REG_ADDR == 7'h00 && !FIFO_RST) |=> REG_RDATA[10])
    else $error("aging flag missing");

  c_grant: cover property (TX_REQ.valid && TX_GRANT);
  c_refuse: cover property (TX_REQ.valid && !TX_GRANT);
  c_store: cover property (WR_CMD.valid);
  c_read: cover property (REG_RD ##1 REG_RDATA != 32'h0);
endmodule

bind ifm_ctrl ifm_ctrl_sva chk (.CLOCK(CLOCK), .NRST(NRST), .FIFO_RST(FIFO_RST), .REG_ADDR(REG_ADDR),
  .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .RX_PLANE(RX_PLANE),
  .RX_FLOWCTL(RX_FLOWCTL), .RX_AGED(RX_AGED), .WR_CMD(WR_CMD), .TX_REQ(TX_REQ), .TX_GRANT(TX_GRANT),
  .RD_CMD(RD_CMD));

// ### bench/ifm_far_end.sv
/*
  Behavioural MAC receiver and host plane requester facing ifm_ctrl.
  Assumes the core clock; its tasks are called from the bench.
*/
`timescale 1ns/100ps
module ifm_far_end
(
  input  wire logic        clk,
  output ifm_pkg::ifm_rx_s rx_plane,
  output ifm_pkg::ifm_req_s tx_req,
  input  wire logic        tx_grant,
  input  ifm_pkg::ifm_mem_s wr_cmd,
  input  ifm_pkg::ifm_mem_s rd_cmd
);
  import ifm_pkg::*;
  initial
  begin
    rx_plane = '0;
    tx_req = '0;
  end

  // Released port field shows the inverse, so a stale copy is never mistaken for a fresh one
  task send(input logic [3:0] p, input ifm_kind_e k, output logic st, output logic [PTR_W-1:0] a);
    @(posedge clk);
    rx_plane <= '{valid: 1'b1, port: p, kind: k, bad: 1'b0, abort: 1'b0, hiprio: 1'b0};
    @(posedge clk);
    rx_plane.valid <= 1'b0;
    rx_plane.port <= ~p;
    #1 st = wr_cmd.valid;
    a = wr_cmd.addr;
  endtask

  task pull(input logic [3:0] p, output logic g, output logic v, output logic [PTR_W-1:0] a);
    @(posedge clk);
    tx_req <= '{valid: 1'b1, port: p};
    #1 g = tx_grant;
    @(posedge clk);
    tx_req <= '{valid: 1'b0, port: ~p};
    #1 v = rd_cmd.valid;
    a = rd_cmd.addr;
  endtask
endmodule

// ### bench/ifm_ctrl_tb.sv
/*
  Self-checking bench for ifm_ctrl: modes, bounds, flags and counters of buffer 0.
  Assumes the checker is bound and the far end model drives the plane ports.
*/
`timescale 1ns/100ps
module ifm_ctrl_tb;
  import ifm_pkg::*;
  logic clk = 1'b0, nrst = 1'b0, fifo_rst = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, s, g, v;
  logic [6:0] reg_addr = 7'h0;
  logic [31:0] reg_wdata = 32'h0, reg_rdata;
  logic [NPORT-1:0] flowctl = '0, aged = '0;
  logic [PTR_W-1:0] a;
  ifm_rx_s rx;
  ifm_req_s req;
  ifm_mem_s wcmd, rcmd;
  int miscompares = 0, n_compared = 0;
  logic g_w;

  ifm_ctrl DUT (.CLOCK(clk), .NRST(nrst), .FIFO_RST(fifo_rst), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
    .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata), .RX_PLANE(rx), .RX_FLOWCTL(flowctl),
    .RX_AGED(aged), .WR_CMD(wcmd), .TX_REQ(req), .TX_GRANT(g_w), .RD_CMD(rcmd));
  ifm_far_end P (.clk(clk), .rx_plane(rx), .tx_req(req), .tx_grant(g_w), .wr_cmd(wcmd), .rd_cmd(rcmd));

  initial
  begin
    forever #2.5 clk = ~clk;
  end

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task wr(input logic [6:0] ad, input logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= ad;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task rdc(input logic [6:0] ad, input logic [31:0] m, input logic [31:0] exp);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= ad;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata & m, exp);
  endtask

  task stop_test;
    $display("compared %0d miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  initial
  begin
    repeat (4000) @(posedge clk);
    miscompares++;
    stop_test;
  end

  initial
  begin
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    rdc(7'h00, 32'hFFFF_FFFF, 32'h2000_2002);
    rdc(7'h45, 32'hFFFF_FFFF, 32'h0);
    rdc(7'h0C, 32'hFFFF_FFFF, 32'h0);
    wr(7'h10, 32'h0001_0000);
    rdc(7'h10, 32'hFFFF_FFFF, 32'h0001_0000);
    wr(7'h00, 32'h2000_0000);
    wr(7'h10, 32'h0003_0000);
    rdc(7'h10, 32'hFFFF_FFFF, 32'h0001_0000);
    $display("test bounds done");
    P.send(4'h0, KIND_SINGLE, s, a);
    chk({s, 17'h0, a}, {1'b1, 17'h0, 14'h0});
    P.pull(4'h0, g, v, a);
    chk({g, v, 16'h0, a}, {2'b11, 16'h0, 14'h0});
    P.pull(4'h0, g, v, a);
    chk({31'h0, g}, 32'h0);
    wr(7'h00, 32'h2000_0003);
    P.send(4'h0, KIND_SINGLE, s, a);
    chk({s, 17'h0, a}, {1'b1, 17'h0, 14'h1});
    P.pull(4'h0, g, v, a);
    chk({31'h0, g}, 32'h0);
    $display("test normal and tx stop done");
    wr(7'h00, 32'h2000_0001);
    P.send(4'h0, KIND_SINGLE, s, a);
    chk({31'h0, s}, 32'h0);
    P.pull(4'h0, g, v, a);
    chk({g, v, 16'h0, a}, {2'b11, 16'h0, 14'h1});
    rdc(7'h60, 32'hFFFF_FFFF, 32'h1);
    wr(7'h00, 32'h2000_0004);
    P.send(4'h0, KIND_SINGLE, s, a);
    chk({31'h0, s}, 32'h0);
    P.pull(4'h0, g, v, a);
    chk({31'h0, g}, 32'h1);
    $display("test rx stop and replay done");
    @(posedge clk);
    flowctl <= 12'h001;
    aged <= 12'h001;
    @(posedge clk);
    flowctl <= '0;
    aged <= '0;
    rdc(7'h00, 32'h0000_0C00, 32'h0000_0C00);
    wr(7'h00, 32'h2000_0C04);
    rdc(7'h00, 32'h0000_0C00, 32'h0);
    @(posedge clk);
    flowctl <= 12'h001;
    @(posedge clk);
    flowctl <= '0;
    fifo_rst <= 1'b1;
    // Read while the reset is held: replay left the pointers looking full once it is let go
    rdc(7'h00, 32'h0000_FF00, 32'h0000_2000);
    @(posedge clk);
    fifo_rst <= 1'b0;
    $display("test flags done");
    wr(7'h00, 32'h2000_0002);
    P.send(4'h0, KIND_START, s, a);
    chk({31'h0, s}, 32'h0);
    rdc(7'h60, 32'hFFFF_FFFF, 32'h2);
    rdc(7'h20, 32'hFFFF_FFFF, 32'h0);
    rdc(7'h30, 32'hFFFF_FFFF, 32'h0);
    $display("test clear done");
    wr(7'h00, 32'hA040_0000);
    P.send(4'h0, KIND_SINGLE, s, a);
    rdc(7'h00, 32'h0000_000F, 32'h3);
    rdc(7'h70, 32'hFFFF_FFFF, 32'h1);
    wr(7'h00, 32'h2000_000C);
    P.pull(4'h0, g, v, a);
    chk({g, v, 16'h0, a}, {2'b11, 16'h0, 14'h0});
    P.pull(4'h0, g, v, a);
    chk({g, v, 16'h0, a}, {2'b11, 16'h0, 14'h0});
    P.send(4'h0, KIND_SINGLE, s, a);
    chk({31'h0, s}, 32'h0);
    $display("test force and replay to tail done");
    stop_test;
  end
endmodule
